// ---- dv/lpbrs_checker_sva.sv ----
`timescale 1ns/10ps
// Port-level checker of the sequencer
module lpbrs_checker (
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       wait_instr,
  input wire logic       stop_instr,
  input wire logic       irq_request,
  input wire logic       break_request,
  input wire logic       watchdog_disable_option,
  input wire logic       periph_clear_req,
  input wire logic       two_step_second,
  input wire logic       periph_clear_ok,
  input wire logic       two_step_clear,
  input wire logic       clear_permitted,
  input wire logic       cpu_clock_en,
  input wire logic       periph_clock_en,
  input wire logic       bus_clock_source_en,
  input wire logic       oscillator_clock_en,
  input wire logic       clear_int_mask,
  input wire logic       stack_start,
  input wire logic       force_swi_vector,
  input wire logic       watchdog_run
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire run = cpu_clock_en && periph_clock_en && !stack_start;

  // ----
  // Properties
  // ----
  property p_wait_entry;
    wait_instr && run |=> clear_int_mask && !cpu_clock_en && periph_clock_en;
  endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong");
  property p_stop_entry;
    stop_instr && run |=> !cpu_clock_en && !periph_clock_en && !bus_clock_source_en
      && !oscillator_clock_en && clear_int_mask;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop entry wrong");
  property p_wake_wait;
    !cpu_clock_en && periph_clock_en && irq_request && !break_request |=> stack_start;
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("wait wake late");
  property p_blocked;
    periph_clear_req && !clear_permitted && break_request && $past(break_request)
      |=> !periph_clear_ok;
  endproperty
  a_blocked: assert property (p_blocked) else $error("clear not blocked");
  property p_ok_cause;
    periph_clear_ok |-> $past(periph_clear_req);
  endproperty
  a_ok_cause: assert property (p_ok_cause) else $error("clear without request");
  property p_swi;
    1'b1 |=> force_swi_vector == $past(break_request);
  endproperty
  a_swi: assert property (p_swi) else $error("vector force wrong");
  property p_stop_delay;
    !periph_clock_en && $rose(irq_request) |=> !stack_start [*8];
  endproperty
  a_stop_delay: assert property (p_stop_delay) else $error("stop wake early");
  property p_rdata;
    reg_rdata != 8'h00 |-> $past(reg_read);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data unasked");
  property p_watchdog;
    periph_clock_en && !watchdog_disable_option |=> watchdog_run || !periph_clock_en;
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog stopped");
  property p_two_step;
    two_step_clear |-> $past(two_step_second);
  endproperty
  a_two_step: assert property (p_two_step) else $error("two step unasked");

  // Main scenarios reached
  c_wake: cover property (!periph_clock_en ##1 stack_start);
  c_blocked: cover property (periph_clear_req && !clear_permitted);
  c_two_step: cover property (two_step_clear);
endmodule

bind lpbrs_top lpbrs_checker i_lpbrs_checker (
  .clock, .arst_n, .reg_read, .reg_rdata, .wait_instr, .stop_instr, .irq_request,
  .break_request, .watchdog_disable_option, .periph_clear_req, .two_step_second,
  .periph_clear_ok, .two_step_clear, .clear_permitted, .cpu_clock_en, .periph_clock_en,
  .bus_clock_source_en, .oscillator_clock_en, .clear_int_mask, .stack_start,
  .force_swi_vector, .watchdog_run
);

// ---- dv/lpbrs_far_model.sv ----
`timescale 1ns/10ps
// Oscillator source and one peripheral status flag
module lpbrs_far_model (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic flag_set,
  input  wire logic periph_clear_ok,
  output logic      oscillator_clock,
  output logic      flag
);
  // Free-running oscillator, 8 ns, phase unrelated to the bus clock
  initial begin
    oscillator_clock = 1'b0;
    #1.3;
    forever #4 oscillator_clock = ~oscillator_clock;
  end

  // Flag sets on an event, clears only when clearing is granted
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag <= 1'b0;
    end else if (flag_set) begin
      flag <= 1'b1;
    end else if (periph_clear_ok) begin
      flag <= 1'b0;
    end
  end
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`define CK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb;
  localparam int LONG = 64;
  logic        clock, arst_n, oscillator_clock, flag;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [11:0] evs;
  logic        reg_write, reg_read, irq_request, break_request, ext_reset_pin;
  logic        short_recovery_option, wait_instr, stop_instr, periph_clear_req;
  logic        two_step_first, two_step_second, flag_set, por_event, watchdog_event;
  logic        ill_opcode_event, ill_address_event, monitor_entry, low_voltage_event;
  logic        periph_clear_ok, two_step_clear, break_active, clear_permitted;
  logic        cpu_clock_en, periph_clock_en, bus_clock_source_en, oscillator_clock_en;
  logic        clear_int_mask, stack_start, force_swi_vector, watchdog_run;
  logic        watchdog_disable_option;
  int          errors, compares, n, lim;

  // Event pulses share one vector
  assign {stop_instr, wait_instr, periph_clear_req, two_step_first, two_step_second,
          flag_set, por_event, watchdog_event, ill_opcode_event, ill_address_event,
          monitor_entry, low_voltage_event} = evs;

  lpbrs_top #(.RECOVERY_LONG(LONG)) i_lpbrs_top (
    .clock, .arst_n, .oscillator_clock, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .wait_instr, .stop_instr, .irq_request, .break_request, .ext_reset_pin,
    .por_event, .watchdog_event, .ill_opcode_event, .ill_address_event,
    .low_voltage_event, .monitor_entry, .vector_hi(8'hFF), .vector_lo(8'hFF),
    .short_recovery_option, .watchdog_disable_option, .periph_clear_req,
    .two_step_first, .two_step_second, .periph_clear_ok, .two_step_clear, .break_active,
    .clear_permitted, .cpu_clock_en, .periph_clock_en, .bus_clock_source_en,
    .oscillator_clock_en, .clear_int_mask, .stack_start, .force_swi_vector, .watchdog_run);

  lpbrs_far_model i_lpbrs_far_model (
    .clock, .arst_n, .flag_set, .periph_clear_ok, .oscillator_clock, .flag);

  // Bus clock, 4 ns
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----
  // Bus and event tasks
  // ----
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic chk_rd(logic [15:0] a, logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 `CK(reg_rdata, e)
  endtask

  task automatic fire(logic [11:0] v);
    @(posedge clock);
    evs <= v;
    @(posedge clock);
    evs <= '0;
    #1;
  endtask

  task automatic brk(logic b);
    @(posedge clock);
    break_request <= b;
    repeat (3) @(posedge clock);
  endtask

  task automatic do_wait(logic b);
    fire(12'h400);
    `CK(clear_int_mask, 1'b1)
    `CK({cpu_clock_en, periph_clock_en, watchdog_run}, {2'b01, ~watchdog_disable_option})
    @(posedge clock);
    if (b) break_request <= 1'b1;
    else irq_request <= 1'b1;
    @(posedge clock);
    break_request <= 1'b0;
    irq_request   <= 1'b0;
    #1 `CK(b ? force_swi_vector : stack_start, 1'b1)
    repeat (4) @(posedge clock);
  endtask

  task automatic stop_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    {arst_n, reg_addr, reg_wdata, reg_write, reg_read, evs} = '0;
    {irq_request, break_request, ext_reset_pin, short_recovery_option} = '0;
    watchdog_disable_option = 1'b0;
    {errors, compares} = '0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    chk_rd(16'hFE00, 8'h00);
    chk_rd(16'hFE03, 8'h00);
    chk_rd(16'hFE01, 8'h80);
    chk_rd(16'hFE01, 8'h00);
    wr(16'hFE02, 8'hFF);
    chk_rd(16'hFE02, 8'h00);
    chk_rd(16'hFE03, 8'h00);
    for (int i = 0; i < 5; i++) begin
      fire(12'h001 << i);
      chk_rd(16'hFE01, 8'h02 << i);
    end
    ext_reset_pin <= 1'b1;
    repeat (6) @(posedge clock);
    ext_reset_pin <= 1'b0;
    repeat (6) @(posedge clock);
    chk_rd(16'hFE01, 8'h40);
    fire(12'h011);
    chk_rd(16'hFE01, 8'h22);
    fire(12'h010);
    fire(12'h020);
    chk_rd(16'hFE01, 8'h80);
    do_wait(1'b1);
    chk_rd(16'hFE00, 8'h02);
    @(posedge clock);
    watchdog_disable_option <= 1'b1;
    do_wait(1'b0);
    @(posedge clock);
    watchdog_disable_option <= 1'b0;
    chk_rd(16'hFE00, 8'h00);
    do_wait(1'b1);
    wr(16'hFE00, 8'h00);
    chk_rd(16'hFE00, 8'h00);
    fire(12'h140);
    brk(1'b1);
    fire(12'h200);
    `CK(periph_clear_ok, 1'b0)
    `CK({break_active, clear_permitted}, 2'b10)
    fire(12'h080);
    `CK(two_step_clear, 1'b0)
    `CK(flag, 1'b1)
    brk(1'b0);
    fire(12'h080);
    `CK(two_step_clear, 1'b1)
    wr(16'hFE03, 8'h80);
    chk_rd(16'hFE03, 8'h80);
    brk(1'b1);
    `CK(clear_permitted, 1'b1)
    fire(12'h200);
    `CK(periph_clear_ok, 1'b1)
    brk(1'b0);
    `CK(flag, 1'b0)
    for (int s = 0; s < 2; s++) begin
      @(posedge clock);
      short_recovery_option <= s[0];
      lim = s ? 32 : LONG;
      fire(12'h800);
      `CK({cpu_clock_en, periph_clock_en, bus_clock_source_en, oscillator_clock_en},
          4'h0)
      repeat (3) @(posedge clock);
      irq_request <= 1'b1;
      n = 0;
      while (stack_start !== 1'b1 && n < 600) begin
        @(posedge clock);
        #1 n++;
      end
      @(posedge clock);
      irq_request <= 1'b0;
      if (n == 600) begin
        errors++;
        stop_test();
      end
      `CK(n >= 2 * lim - 6 && n <= 2 * lim + 16, 1'b1)
      repeat (4) @(posedge clock);
    end
    stop_test();
  end
endmodule

// ---- hdl/lpbrs_map.svh ----
`ifndef LPBRS_MAP_SVH
`define LPBRS_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LPBRS_ADDR_BREAK_STATUS  16'hFE00
`define LPBRS_ADDR_RESET_CAUSE   16'hFE01
`define LPBRS_ADDR_FLAG_CONTROL  16'hFE03
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LPBRS_BIT_EXITED_WAIT    1
`define LPBRS_BIT_CLEAR_ENABLE   7
`define LPBRS_BIT_POWER_ON       7
`define LPBRS_BIT_PIN            6
`define LPBRS_BIT_WATCHDOG       5
`define LPBRS_BIT_ILL_OPCODE     4
`define LPBRS_BIT_ILL_ADDRESS    3
`define LPBRS_BIT_MONITOR        2
`define LPBRS_BIT_LOW_VOLTAGE    1
// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define LPBRS_RST_RESET_CAUSE    8'h80
`define LPBRS_RECOVERY_LONG      4096
`define LPBRS_RECOVERY_SHORT     32
`define LPBRS_PRESCALE_WIDTH     13
`define LPBRS_VECTOR_BLANK       8'hFF
`endif

// ---- hdl/lpbrs_pin_sync.sv ----
`timescale 1ns/10ps
// Three-stage synchroniser, change accepted when stages two and three agree
module lpbrs_pin_sync (
  input  wire logic  clock,
  input  wire logic  arst_n,
  lpbrs_sync_if.src  port
);
  logic [2:0] stage;
  logic       level_q;

  // Shift chain
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], port.raw};
    end
  end

  // Accept on agreement
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      level_q <= 1'h0;
    end else if (stage[1] == stage[2]) begin
      level_q <= stage[2];
    end
  end

  assign port.level = level_q;
endmodule

// ---- hdl/lpbrs_pkg.sv ----
package lpbrs_pkg;
  // Power sequencing states
  typedef enum logic [2:0] {
    LPBRS_RUN,
    LPBRS_WAIT,
    LPBRS_STOP,
    LPBRS_RECOVER,
    LPBRS_STACK
  } lpbrs_state_t;
endpackage

// ---- hdl/lpbrs_prescale.sv ----
`timescale 1ns/10ps
`include "lpbrs_map.svh"
// Prescale counter on the falling oscillator edge
module lpbrs_prescale
  import lpbrs_pkg::*;
#(
  parameter int WIDTH = `LPBRS_PRESCALE_WIDTH
) (
  input  wire logic             oscillator_clock,
  input  wire logic             arst_n,
  input  wire logic             hold_clear,
  output logic [WIDTH-1:0]      count
);
  // Falling edge count, cleared while held
  always_ff @(negedge oscillator_clock or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (hold_clear) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule

// ---- hdl/lpbrs_sync_if.sv ----
`timescale 1ns/10ps
// Carrier between the pin synchroniser and the top
interface lpbrs_sync_if;
  logic raw;
  logic level;
  modport src (input raw, output level);
  modport dst (output raw, input level);
endinterface

// ---- hdl/lpbrs_top.sv ----
// Behaviour
// [R1] With clear enable low during break, peripheral flag clearing is blocked.
// [R2] With clear enable high, break clears work and stay cleared afterwards.
// [R3] Two-step flags stay protected in break; second step after break clears.
// [R4] Wait or stop entry clears the CPU interrupt mask and unclocks CPU.
// [R5] Wait stops CPU clocks; peripheral clocks keep running.
// [R6] Enabled interrupt wakes from wait; stacking starts one cycle later.
// [R7] Reset or break ends wait; break exit sets exited-wait flag.
// [R8] Watchdog disable option zero keeps watchdog running during wait.
// [R9] Stop clears prescale counter and disables both clock outputs.
// [R10] Stop ends on interrupt, reset or break; stacking after recovery delay.
// [R11] Recovery lasts 4096 oscillator cycles, or 32 with short option.
// [R12] Prescaler held clear from stop until recovery, then times recovery.
// [R13] Three registers at FE00, FE01 and FE03.
// [R14] Writing zero clears exited-wait flag; set only by break wait exit.
// [R15] Reading reset cause register clears all its flags.
// [R16] Power-on sets own flag, clears others; other sources only add.
// [R17] Separate flags for pin, watchdog, opcode, address and low voltage.
// [R18] Monitor flag set on monitor entry with blank reset vector bytes; code sets it only on the first such entry after power-on.
// [R19] Prescale counter is 13 bits, advancing on falling oscillator edge.
// [R20] Break request forces CPU to software interrupt vector.
// [R21] Break-active and clear-permitted broadcast to all peripherals.
`timescale 1ns/10ps
`include "lpbrs_map.svh"
module lpbrs_top
  import lpbrs_pkg::*;
#(
  parameter int RECOVERY_LONG  = `LPBRS_RECOVERY_LONG,
  parameter int RECOVERY_SHORT = `LPBRS_RECOVERY_SHORT,
  parameter int PS_WIDTH       = `LPBRS_PRESCALE_WIDTH
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        oscillator_clock,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        wait_instr,
  input  wire logic        stop_instr,
  input  wire logic        irq_request,
  input  wire logic        break_request,
  input  wire logic        ext_reset_pin,
  input  wire logic        por_event,
  input  wire logic        watchdog_event,
  input  wire logic        ill_opcode_event,
  input  wire logic        ill_address_event,
  input  wire logic        low_voltage_event,
  input  wire logic        monitor_entry,
  input  wire logic [7:0]  vector_hi,
  input  wire logic [7:0]  vector_lo,
  input  wire logic        short_recovery_option,
  input  wire logic        watchdog_disable_option,
  input  wire logic        periph_clear_req,
  input  wire logic        two_step_first,
  input  wire logic        two_step_second,
  output logic             periph_clear_ok,
  output logic             two_step_clear,
  output logic             break_active,
  output logic             clear_permitted,
  output logic             cpu_clock_en,
  output logic             periph_clock_en,
  output logic             bus_clock_source_en,
  output logic             oscillator_clock_en,
  output logic             clear_int_mask,
  output logic             stack_start,
  output logic             force_swi_vector,
  output logic             watchdog_run
);
  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  lpbrs_sync_if pin_bus ();
  assign pin_bus.raw = ext_reset_pin;
  lpbrs_pin_sync u_pin_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .port   (pin_bus)
  );
  logic pin_level_q;
  logic pin_rise;
  assign pin_rise = pin_bus.level & ~pin_level_q;

  // ----------------------------------------
  // Prescale counter and recovery
  // ----------------------------------------
  lpbrs_state_t        state;
  lpbrs_state_t        next_state;
  logic [PS_WIDTH-1:0] ps_count;
  logic                ps_hold;
  logic [PS_WIDTH:0]   recover_len;
  logic                recover_done;
  logic                rec_sync_a;
  logic                rec_sync_b;
  logic                rec_sync_c;

  // [R12] Held clear until recovery
  assign ps_hold = (state == LPBRS_STOP);
  // [R19] Thirteen bit falling-edge count
  lpbrs_prescale #(
    .WIDTH (PS_WIDTH)
  ) u_prescale (
    .oscillator_clock (oscillator_clock),
    .arst_n           (arst_n),
    .hold_clear       (ps_hold),
    .count            (ps_count)
  );

  // [R11] Recovery length select
  assign recover_len = short_recovery_option ? (PS_WIDTH+1)'(RECOVERY_SHORT)
                                             : (PS_WIDTH+1)'(RECOVERY_LONG);
  // Reaching the last count, compared one bit wider than the counter
  logic reached_raw;
  assign reached_raw = (state == LPBRS_RECOVER) &&
                       ({1'b0, ps_count} == recover_len - 1'b1);

  // Crossing the oscillator-domain terminal count
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rec_sync_a <= 1'b0;
      rec_sync_b <= 1'b0;
      rec_sync_c <= 1'b0;
    end else begin
      rec_sync_a <= reached_raw;
      rec_sync_b <= rec_sync_a;
      rec_sync_c <= rec_sync_b;
    end
  end
  assign recover_done = rec_sync_b & rec_sync_c;

  // ----------------------------------------
  // Power sequencing
  // ----------------------------------------
  logic wake_event;
  logic monitor_reset;
  logic any_reset;
  logic break_q;
  logic wait_exit_by_break;
  assign any_reset = por_event | pin_rise | watchdog_event | ill_opcode_event |
                     ill_address_event | low_voltage_event | monitor_reset;
  assign wake_event = irq_request | break_request | any_reset;
  // [R7] Break exit from wait
  assign wait_exit_by_break = (state == LPBRS_WAIT) & break_request;

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      LPBRS_RUN: begin
        if (stop_instr) begin
          next_state = LPBRS_STOP;
        end else if (wait_instr) begin
          next_state = LPBRS_WAIT;
        end
      end
      LPBRS_WAIT: begin
        // [R6] Interrupt wakes, stack next
        if (any_reset) begin
          next_state = LPBRS_RUN;
        end else if (irq_request | break_request) begin
          next_state = LPBRS_STACK;
        end
      end
      LPBRS_STOP: begin
        // [R10] Leave stop into recovery
        if (wake_event) begin
          next_state = LPBRS_RECOVER;
        end
      end
      LPBRS_RECOVER: begin
        if (recover_done) begin
          next_state = LPBRS_STACK;
        end
      end
      LPBRS_STACK: begin
        next_state = LPBRS_RUN;
      end
      default: begin
        next_state = LPBRS_RUN;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= LPBRS_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Clock gating and strobes
  logic next_cpu_clk;
  logic next_periph_clk;
  logic next_osc_en;
  // [R5] Wait keeps peripherals clocked
  assign next_periph_clk = (next_state != LPBRS_STOP) && (next_state != LPBRS_RECOVER);
  // [R4] CPU unclocked in low power
  assign next_cpu_clk = (next_state == LPBRS_RUN) || (next_state == LPBRS_STACK);
  // [R9] Stop disables clock outputs
  assign next_osc_en = (next_state != LPBRS_STOP);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cpu_clock_en        <= 1'b1;
      periph_clock_en     <= 1'b1;
      bus_clock_source_en <= 1'b1;
      oscillator_clock_en <= 1'b1;
      clear_int_mask      <= 1'b0;
      stack_start         <= 1'b0;
      force_swi_vector    <= 1'b0;
      watchdog_run        <= 1'b0;
      break_q             <= 1'b0;
      pin_level_q         <= 1'b0;
    end else begin
      cpu_clock_en        <= next_cpu_clk;
      periph_clock_en     <= next_periph_clk;
      bus_clock_source_en <= next_osc_en;
      oscillator_clock_en <= next_osc_en;
      // [R4] Mask cleared on entry
      clear_int_mask      <= (state == LPBRS_RUN) & (stop_instr | wait_instr);
      stack_start         <= (next_state == LPBRS_STACK);
      // [R20] Break to SWI vector
      force_swi_vector    <= break_request;
      // [R8] Watchdog in run and wait
      watchdog_run        <= ~watchdog_disable_option & (next_state != LPBRS_STOP);
      break_q             <= break_request;
      pin_level_q         <= pin_bus.level;
    end
  end

  // ----------------------------------------
  // Break flag protection
  // ----------------------------------------
  logic clear_enable;
  logic break_mode;
  logic permit;
  logic first_seen;
  assign break_mode = break_request | break_q;
  // [R1] Block clears in break
  assign permit = ~break_mode | clear_enable;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      first_seen      <= 1'b0;
      periph_clear_ok <= 1'b0;
      two_step_clear  <= 1'b0;
      break_active    <= 1'b0;
      clear_permitted <= 1'b1;
    end else begin
      // [R3] First step survives break
      if (two_step_first) begin
        first_seen <= 1'b1;
      end else if (two_step_second & permit) begin
        first_seen <= 1'b0;
      end
      // [R2] Clears pass when enabled
      periph_clear_ok <= periph_clear_req & permit;
      two_step_clear  <= two_step_second & first_seen & permit;
      // [R21] Broadcast to peripherals
      break_active    <= break_mode;
      clear_permitted <= permit;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic       exited_wait;
  logic [7:0] cause;
  logic       monitor_armed;
  logic       sel_status;
  logic       sel_cause;
  logic       sel_control;
  logic       cause_clear;
  logic [7:0] next_rdata;
  logic [7:0] cause_set;

  // [R13] Address decode
  assign sel_status  = (reg_addr == `LPBRS_ADDR_BREAK_STATUS);
  assign sel_cause   = (reg_addr == `LPBRS_ADDR_RESET_CAUSE);
  assign sel_control = (reg_addr == `LPBRS_ADDR_FLAG_CONTROL);
  assign cause_clear = reg_read & sel_cause;

  // [R18] Monitor entry with blank vectors
  assign monitor_reset = monitor_entry & monitor_armed &
                         (vector_hi == `LPBRS_VECTOR_BLANK) &
                         (vector_lo == `LPBRS_VECTOR_BLANK);

  // [R17] One flag per source
  assign cause_set = {1'b0, pin_rise, watchdog_event, ill_opcode_event,
                      ill_address_event, monitor_reset, low_voltage_event, 1'b0};

  // Read data mux
  always_comb begin
    next_rdata = 8'h00;
    if (sel_status) begin
      next_rdata[`LPBRS_BIT_EXITED_WAIT] = exited_wait;
    end else if (sel_cause) begin
      next_rdata = cause;
    end else if (sel_control) begin
      next_rdata[`LPBRS_BIT_CLEAR_ENABLE] = clear_enable;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? next_rdata : 8'h00;
    end
  end

  // Exited-wait flag and clear enable
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      exited_wait  <= 1'b0;
      clear_enable <= 1'b0;
    end else begin
      // [R14] Set wins over write-zero clear
      if (wait_exit_by_break) begin
        exited_wait <= 1'b1;
      end else if ((state == LPBRS_WAIT) & (irq_request | any_reset)) begin
        exited_wait <= 1'b0;
      end else if (reg_write & sel_status & ~reg_wdata[`LPBRS_BIT_EXITED_WAIT]) begin
        exited_wait <= 1'b0;
      end
      if (reg_write & sel_control) begin
        clear_enable <= reg_wdata[`LPBRS_BIT_CLEAR_ENABLE];
      end
    end
  end

  // Reset cause flags
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cause         <= `LPBRS_RST_RESET_CAUSE;
      monitor_armed <= 1'b1;
    end else begin
      if (por_event) begin
        // [R16] Power-on clears the rest
        cause         <= `LPBRS_RST_RESET_CAUSE;
        monitor_armed <= 1'b1;
      end else begin
        // [R15] Read clears, new causes win
        cause <= (cause_clear ? 8'h00 : cause) | cause_set;
        if (monitor_reset) begin
          monitor_armed <= 1'b0;
        end
      end
    end
  end
endmodule
